// ===== hdl/aos_pkg.sv
// constants, register map and state type for the air-over-oil sequencer
package aos_pkg;
    localparam int CLK_MHZ       = 40;
    localparam int DEB_TIME_US   = 5000;
    localparam int DEB_CYCLES    = DEB_TIME_US * CLK_MHZ;
    localparam int BLINK_HALF_CYCLES = 30;

    localparam logic [7:0] PO_AIR_OIL   = 8'h07;
    localparam logic [7:0] RM_MAINTAIN  = 8'h09;

    localparam logic [11:0] ADDR_CTRL   = 12'h000;
    localparam logic [11:0] ADDR_SQZD   = 12'h004;
    localparam logic [11:0] ADDR_BLKD   = 12'h008;
    localparam logic [11:0] ADDR_SCHED0 = 12'h00c;
    localparam logic [11:0] ADDR_SCHED1 = 12'h010;
    localparam logic [11:0] ADDR_STATUS = 12'h014;

    localparam int CTRL_PO_LSB  = 0;
    localparam int CTRL_RM_LSB  = 8;
    localparam int CTRL_REP_BIT = 16;
    localparam int S_SQZ_LSB    = 0;
    localparam int S_WELD_LSB   = 8;
    localparam int S_HOLD_LSB   = 16;
    localparam int S0_OFF_LSB   = 8;
    localparam int S1_OFF_LSB   = 24;

    localparam logic [7:0] TIME_RST = 8'h00;
    localparam logic [7:0] SEL_RST  = 8'h00;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_SQZ_DLY,
        ST_SQZ0,
        ST_SQZ1,
        ST_WELD,
        ST_HOLD,
        ST_BLK_DLY,
        ST_OFF_REM,
        ST_ADV_EXT,
        ST_ADV_STOP
    } aos_state_t;
endpackage : aos_pkg

// ===== hdl/aos_sequencer.sv
// air-over-oil retraction sequencer with apb configuration registers
//
// What this block does
// RULE1: on initiation extend valve comes on first, then intensify, then weld, hold
// RULE2: end of hold drops extend and intensify and starts blocking delay
// RULE3: blocking delay expiry energizes the third (blocking) valve
// RULE4: blocking valve stays on while waiting for the next initiation
// RULE5: blocking valve is off whenever extend valve is on
// RULE6: squeeze delay only when initiated with blocking valve off
// RULE7: retraction sequencing runs only when process output selector is 07
// RULE8: blocking delay register reachable only while selector is 07
// RULE9: toggle from retracted: extend for squeeze delay, advance stop, block
// RULE10: advance stop interval occurs only in toggle advance, never in welds
// RULE11: squeeze delay and advance stop count half line cycles
// RULE12: toggle while blocking valve on turns it off for full retraction
// RULE13: blocking valve on blinks its indicator and refuses register writes
// RULE14: emergency stop aborts, drops all outputs except the third valve in maintained mode 09, blocking stays off after
// RULE15: repeat runs off minus blocking delay after blocking, or blocking only
// RULE16: squeeze lamp half bright in squeeze delay, off lamp in blocking delay
// RULE17: one squeeze delay and blocking delay shared by every schedule
// RULE18: schedule 00 drives extend only, chains to 01 driving both valves
// RULE19: operator holds switch closed, sets mode 09, then opens switch
// RULE20: maintained mode keeps third valve on while retraction switch closed
// RULE21: third valve cannot turn on at power-up with switch already closed
// RULE22: inputs are synchronized, debounced, one edge per momentary closure
`timescale 1ns/1ps
module aos_sequencer #(
    parameter int DEB_CYCLES = aos_pkg::DEB_CYCLES
) (
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        line_half_tick,
    input  wire logic        toggle_input,
    input  wire logic        initiation_input,
    input  wire logic        estop_input,
    input  wire logic        retraction_switch_input,
    output logic             extend_valve,
    output logic             intensify_valve,
    output logic             third_valve_terminal,
    output logic             weld_enable,
    output logic             squeeze_led,
    output logic             off_led,
    output logic             valve3_led
);
    localparam int DEB_W = $clog2(DEB_CYCLES + 1);

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    function automatic logic hit(input logic [11:0] a,
                                 input logic [11:0] off);
        hit = (a == off);
    endfunction : hit

    // input conditioning; bit 0 toggle, 1 initiation, 2 estop, 3 retraction
    wire  [3:0] raw_in = {retraction_switch_input, estop_input,
                          initiation_input, toggle_input};
    logic [3:0] s1_r;
    logic [3:0] s2_r;
    logic [3:0] s3_r;
    logic [3:0] db_r;
    logic [3:0] db_d_r;
    logic [3:0] settled_r;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_deb
            logic [DEB_W-1:0] cnt_r;
            always_ff @(posedge sys_clk)
            begin
                if (!reset_n)
                begin
                    s1_r[gi]      <= 1'b0;
                    s2_r[gi]      <= 1'b0;
                    s3_r[gi]      <= 1'b0;
                    db_r[gi]      <= 1'b0;
                    db_d_r[gi]    <= 1'b0;
                    settled_r[gi] <= 1'b0;
                    cnt_r         <= '0;
                end
                else
                begin
                    s1_r[gi]   <= raw_in[gi];
                    s2_r[gi]   <= s1_r[gi];
                    s3_r[gi]   <= s2_r[gi];
                    db_d_r[gi] <= db_r[gi];
                    if (s2_r[gi] != s3_r[gi])
                        cnt_r <= '0; // RULE22
                    else if (cnt_r != DEB_W'(DEB_CYCLES - 1))
                        cnt_r <= cnt_r + 1'b1;
                    else
                    begin
                        db_r[gi]      <= s3_r[gi]; // RULE22
                        settled_r[gi] <= 1'b1;
                    end
                end
            end
        end
    endgenerate

    wire tog_rise  = db_r[0] & ~db_d_r[0]; // RULE22
    wire ini_rise  = db_r[1] & ~db_d_r[1];
    wire ini_lvl   = db_r[1];
    wire estop_lvl = db_r[2];
    wire ret_lvl   = db_r[3];

    // configuration registers
    logic [7:0] po_r;
    logic [7:0] rm_r;
    logic       rep_r;
    logic [7:0] sqzd_r;
    logic [7:0] blkd_r;
    logic [7:0] s0_sqz_r;
    logic [7:0] s0_off_r;
    logic [7:0] s1_sqz_r;
    logic [7:0] s1_weld_r;
    logic [7:0] s1_hold_r;
    logic [7:0] s1_off_r;

    // sequencer state; local aliases keep the state names short
    localparam aos_pkg::aos_state_t ST_IDLE     = aos_pkg::ST_IDLE;
    localparam aos_pkg::aos_state_t ST_SQZ_DLY  = aos_pkg::ST_SQZ_DLY;
    localparam aos_pkg::aos_state_t ST_SQZ0     = aos_pkg::ST_SQZ0;
    localparam aos_pkg::aos_state_t ST_SQZ1     = aos_pkg::ST_SQZ1;
    localparam aos_pkg::aos_state_t ST_WELD     = aos_pkg::ST_WELD;
    localparam aos_pkg::aos_state_t ST_HOLD     = aos_pkg::ST_HOLD;
    localparam aos_pkg::aos_state_t ST_BLK_DLY  = aos_pkg::ST_BLK_DLY;
    localparam aos_pkg::aos_state_t ST_OFF_REM  = aos_pkg::ST_OFF_REM;
    localparam aos_pkg::aos_state_t ST_ADV_EXT  = aos_pkg::ST_ADV_EXT;
    localparam aos_pkg::aos_state_t ST_ADV_STOP = aos_pkg::ST_ADV_STOP;
    aos_pkg::aos_state_t state_r;
    aos_pkg::aos_state_t st_nxt;
    logic [9:0] tmr_r;
    logic [9:0] ld_val;
    logic       ld;
    logic       blk_r;
    logic       blk_nxt;
    logic       armed_r;
    logic       blink_r;
    logic       pwm_r;
    logic [7:0] blink_cnt_r;

    wire aoo     = (po_r == aos_pkg::PO_AIR_OIL); // RULE7
    wire mc_mode = ~aoo & (rm_r == aos_pkg::RM_MAINTAIN);
    wire abort   = estop_lvl | ~aoo; // RULE14
    wire tmr_done = (tmr_r == 10'h000);

    // apb decode; one wait state, answer registered
    wire hit_ctrl = hit(paddr, aos_pkg::ADDR_CTRL);
    wire hit_sqzd = hit(paddr, aos_pkg::ADDR_SQZD);
    wire hit_blkd = hit(paddr, aos_pkg::ADDR_BLKD);
    wire hit_s0   = hit(paddr, aos_pkg::ADDR_SCHED0);
    wire hit_s1   = hit(paddr, aos_pkg::ADDR_SCHED1);
    wire hit_stat = hit(paddr, aos_pkg::ADDR_STATUS);
    wire mapped   = hit_ctrl | hit_sqzd | hit_blkd | hit_s0 | hit_s1 |
                    hit_stat;
    // a live blocking valve locks the whole schedule against edits
    wire bad      = ~mapped | (hit_blkd & ~aoo) | // RULE8
                    (pwrite & (blk_r | hit_stat)); // RULE13
    wire acc_wait = psel & penable & ~pready;
    wire wr_ok    = psel & penable & pready & pwrite & ~pslverr;
    wire [31:0] status_word = {22'h000000, state_r, armed_r, weld_enable,
                               blk_r, intensify_valve, extend_valve,
                               estop_lvl};
    wire [31:0] rd_data =
        hit_ctrl ? {15'h0000, rep_r, rm_r, po_r} :
        hit_sqzd ? {24'h000000, sqzd_r} :
        hit_blkd ? {24'h000000, blkd_r} :
        hit_s0   ? {16'h0000, s0_off_r, s0_sqz_r} :
        hit_s1   ? {s1_off_r, s1_hold_r, s1_weld_r, s1_sqz_r} :
        hit_stat ? status_word : 32'h00000000;

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end
        else
        begin
            pready  <= acc_wait;
            pslverr <= acc_wait & bad;
            prdata  <= (acc_wait & ~bad & ~pwrite) ? rd_data : 32'h00000000;
        end
    end

    // RULE17: delays are global, not per schedule
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            po_r      <= aos_pkg::SEL_RST;
            rm_r      <= aos_pkg::SEL_RST;
            rep_r     <= 1'b0;
            sqzd_r    <= aos_pkg::TIME_RST;
            blkd_r    <= aos_pkg::TIME_RST;
            s0_sqz_r  <= aos_pkg::TIME_RST;
            s0_off_r  <= aos_pkg::TIME_RST;
            s1_sqz_r  <= aos_pkg::TIME_RST;
            s1_weld_r <= aos_pkg::TIME_RST;
            s1_hold_r <= aos_pkg::TIME_RST;
            s1_off_r  <= aos_pkg::TIME_RST;
        end
        else if (wr_ok)
        begin
            if (hit_ctrl)
            begin
                po_r  <= pwdata[aos_pkg::CTRL_PO_LSB +: 8];
                rm_r  <= pwdata[aos_pkg::CTRL_RM_LSB +: 8];
                rep_r <= pwdata[aos_pkg::CTRL_REP_BIT];
            end
            if (hit_sqzd)
                sqzd_r <= pwdata[7:0];
            if (hit_blkd)
                blkd_r <= pwdata[7:0];
            if (hit_s0)
            begin
                s0_sqz_r <= pwdata[aos_pkg::S_SQZ_LSB +: 8];
                s0_off_r <= pwdata[aos_pkg::S0_OFF_LSB +: 8];
            end
            if (hit_s1)
            begin
                s1_sqz_r  <= pwdata[aos_pkg::S_SQZ_LSB +: 8];
                s1_weld_r <= pwdata[aos_pkg::S_WELD_LSB +: 8];
                s1_hold_r <= pwdata[aos_pkg::S_HOLD_LSB +: 8];
                s1_off_r  <= pwdata[aos_pkg::S1_OFF_LSB +: 8];
            end
        end
    end

    // timer counts half line cycles; full-cycle times are doubled
    wire [9:0] sqzd_half = {2'b00, sqzd_r}; // RULE11
    wire [9:0] stop_half = {2'b00, s0_off_r}; // RULE11
    wire [9:0] s0_full   = {1'b0, s0_sqz_r, 1'b0};
    wire [9:0] s1_full   = {1'b0, s1_sqz_r, 1'b0};
    wire [9:0] weld_full = {1'b0, s1_weld_r, 1'b0};
    wire [9:0] hold_full = {1'b0, s1_hold_r, 1'b0};
    wire [9:0] blk_full  = {1'b0, blkd_r, 1'b0};
    wire [7:0] off_rem   = s1_off_r - blkd_r;
    wire [9:0] rem_full  = {1'b0, off_rem, 1'b0};

    always_comb
    begin
        st_nxt = state_r;
        ld     = 1'b0;
        ld_val = 10'h000;
        case (state_r)
            ST_IDLE:
                if (ini_rise)
                begin
                    ld = 1'b1;
                    if (blk_r)
                    begin
                        st_nxt = ST_SQZ0; // RULE6
                        ld_val = s0_full;
                    end
                    else
                    begin
                        st_nxt = ST_SQZ_DLY; // RULE6
                        ld_val = sqzd_half;
                    end
                end
                else if (tog_rise && !blk_r)
                begin
                    st_nxt = ST_ADV_EXT; // RULE9
                    ld     = 1'b1;
                    ld_val = sqzd_half;
                end
            ST_SQZ_DLY:
                if (tmr_done)
                begin
                    st_nxt = ST_SQZ0;
                    ld     = 1'b1;
                    ld_val = s0_full;
                end
            ST_SQZ0:
                if (tmr_done)
                begin
                    st_nxt = ST_SQZ1; // RULE18
                    ld     = 1'b1;
                    ld_val = s1_full;
                end
            ST_SQZ1:
                if (tmr_done)
                begin
                    st_nxt = ST_WELD;
                    ld     = 1'b1;
                    ld_val = weld_full;
                end
            ST_WELD:
                if (tmr_done)
                begin
                    st_nxt = ST_HOLD;
                    ld     = 1'b1;
                    ld_val = hold_full;
                end
            ST_HOLD:
                if (tmr_done)
                begin
                    st_nxt = ST_BLK_DLY; // RULE2
                    ld     = 1'b1;
                    ld_val = blk_full;
                end
            ST_BLK_DLY:
                if (tmr_done)
                begin
                    ld = 1'b1;
                    if (!(rep_r && ini_lvl))
                        st_nxt = ST_IDLE; // RULE4
                    else if (s1_off_r > blkd_r)
                    begin
                        st_nxt = ST_OFF_REM; // RULE15
                        ld_val = rem_full;
                    end
                    else
                    begin
                        st_nxt = ST_SQZ0; // RULE15
                        ld_val = s0_full;
                    end
                end
            ST_OFF_REM:
                if (tmr_done)
                begin
                    st_nxt = ST_SQZ0;
                    ld     = 1'b1;
                    ld_val = s0_full;
                end
            ST_ADV_EXT:
                if (tmr_done)
                begin
                    st_nxt = ST_ADV_STOP; // RULE10
                    ld     = 1'b1;
                    ld_val = stop_half;
                end
            ST_ADV_STOP:
                if (tmr_done)
                    st_nxt = ST_IDLE;
            default:
                st_nxt = ST_IDLE;
        endcase
        if (abort)
        begin
            st_nxt = ST_IDLE; // RULE14
            ld     = 1'b0;
        end
    end

    wire ext_nxt = (st_nxt == ST_SQZ_DLY) | (st_nxt == ST_SQZ0) |
                   (st_nxt == ST_SQZ1) | (st_nxt == ST_WELD) |
                   (st_nxt == ST_HOLD) | (st_nxt == ST_ADV_EXT); // RULE1
    wire int_nxt = (st_nxt == ST_SQZ1) | (st_nxt == ST_WELD) |
                   (st_nxt == ST_HOLD); // RULE18
    wire blk_set = tmr_done & ((state_r == ST_BLK_DLY) |
                               (state_r == ST_ADV_STOP));
    wire blk_clr = (state_r == ST_IDLE) & tog_rise & ~ini_rise;

    always_comb
    begin
        if (mc_mode)
            blk_nxt = ret_lvl & armed_r; // RULE20 RULE21
        else if (abort || ext_nxt)
            blk_nxt = 1'b0; // RULE5 RULE14
        else if (blk_set)
            blk_nxt = 1'b1; // RULE3 RULE9
        else if (blk_clr)
            blk_nxt = 1'b0; // RULE12
        else
            blk_nxt = blk_r; // RULE4
    end

    // interlock re-arms only after a settled open switch in mode 09
    wire armed_nxt = mc_mode & (armed_r | (settled_r[3] & ~ret_lvl)); // RULE21

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            state_r <= ST_IDLE;
            tmr_r   <= 10'h000;
            blk_r   <= 1'b0;
            armed_r <= 1'b0;
        end
        else
        begin
            state_r <= st_nxt;
            if (ld)
                tmr_r <= ld_val;
            else if (line_half_tick && !tmr_done)
                tmr_r <= tmr_r - 10'h001; // RULE11
            blk_r   <= blk_nxt;
            armed_r <= armed_nxt;
        end
    end

    // lamps: dim is a 50% duty on the clock, blink paced by line cycles
    wire blink_wrap = (blink_cnt_r ==
                       8'(aos_pkg::BLINK_HALF_CYCLES - 1));
    wire sqz_on  = (st_nxt == ST_SQZ_DLY) | (st_nxt == ST_SQZ0) |
                   (st_nxt == ST_SQZ1);
    wire off_on  = (st_nxt == ST_BLK_DLY) | (st_nxt == ST_OFF_REM);

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            pwm_r       <= 1'b0;
            blink_r     <= 1'b0;
            blink_cnt_r <= 8'h00;
        end
        else
        begin
            pwm_r <= ~pwm_r;
            if (line_half_tick)
            begin
                blink_cnt_r <= blink_wrap ? 8'h00 : blink_cnt_r + 8'h01;
                if (blink_wrap)
                    blink_r <= ~blink_r;
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            extend_valve         <= 1'b0;
            intensify_valve      <= 1'b0;
            third_valve_terminal <= 1'b0;
            weld_enable          <= 1'b0;
            squeeze_led          <= 1'b0;
            off_led              <= 1'b0;
            valve3_led           <= 1'b0;
        end
        else
        begin
            extend_valve         <= ext_nxt;
            intensify_valve      <= int_nxt;
            third_valve_terminal <= blk_nxt;
            weld_enable          <= (st_nxt == ST_WELD);
            squeeze_led <= sqz_on & ~((st_nxt == ST_SQZ_DLY) & pwm_r); // RULE16
            off_led     <= off_on & ~((st_nxt == ST_BLK_DLY) & pwm_r); // RULE16
            valve3_led  <= blk_nxt & blink_r; // RULE13
        end
    end

    property p_ext_first;
        $rose(intensify_valve) |-> $past(extend_valve);
    endproperty
    a_ext_first: assert property (p_ext_first) // RULE1
        else $error("intensify rose without extend");

    property p_hold_end;
        (state_r == ST_HOLD && st_nxt == ST_BLK_DLY) |=>
            !extend_valve && !intensify_valve && state_r == ST_BLK_DLY;
    endproperty
    a_hold_end: assert property (p_hold_end) // RULE2
        else $error("valves not dropped at end of hold");

    property p_blk_on;
        // an immediate repeat goes straight to extend, which wins
        (state_r == ST_BLK_DLY && tmr_done && !abort && !mc_mode &&
         !(rep_r && ini_lvl && s1_off_r <= blkd_r)) |=>
            third_valve_terminal ##1 third_valve_terminal;
    endproperty
    a_blk_on: assert property (p_blk_on) // RULE3
        else $error("blocking valve not on after delay");

    property p_ext_excl;
        extend_valve |-> !third_valve_terminal;
    endproperty
    a_ext_excl: assert property (p_ext_excl) // RULE5
        else $error("extend and blocking valve both on");

    property p_sqz_dly;
        (state_r == ST_IDLE && ini_rise && !abort) |=>
            state_r == ($past(blk_r) ? ST_SQZ0 : ST_SQZ_DLY);
    endproperty
    a_sqz_dly: assert property (p_sqz_dly) // RULE6
        else $error("wrong start state after initiation");

    property p_tog_off;
        (state_r == ST_IDLE && blk_r && tog_rise && !ini_rise && !abort
         && !mc_mode) |=> !third_valve_terminal;
    endproperty
    a_tog_off: assert property (p_tog_off) // RULE12
        else $error("toggle did not release blocking valve");

    property p_estop;
        estop_lvl && !mc_mode |=> state_r == ST_IDLE && !extend_valve &&
            !intensify_valve && !weld_enable && !third_valve_terminal;
    endproperty
    a_estop: assert property (p_estop) // RULE14
        else $error("emergency stop left an output on");

    property p_adv_stop;
        (state_r == ST_ADV_STOP && $past(state_r) != ST_ADV_STOP) |->
            $past(state_r) == ST_ADV_EXT;
    endproperty
    a_adv_stop: assert property (p_adv_stop) // RULE10
        else $error("advance stop entered outside toggle advance");

    property p_lock;
        (acc_wait && pwrite && blk_r) |=> pready && pslverr;
    endproperty
    a_lock: assert property (p_lock) // RULE13
        else $error("write accepted while blocking valve on");

    property p_blkd_gate;
        (acc_wait && hit_blkd && !aoo) |=> pslverr ##1 $stable(blkd_r);
    endproperty
    a_blkd_gate: assert property (p_blkd_gate) // RULE8
        else $error("blocking delay reached outside mode 07");

    property p_interlock;
        (mc_mode && !armed_r) |=> !third_valve_terminal;
    endproperty
    a_interlock: assert property (p_interlock) // RULE21
        else $error("third valve on before interlock armed");

    property p_dim;
        (st_nxt == ST_SQZ_DLY)[*2] |=> squeeze_led != $past(squeeze_led);
    endproperty
    a_dim: assert property (p_dim) // RULE16
        else $error("squeeze lamp not dimmed in squeeze delay");
endmodule : aos_sequencer

// ===== tb/aos_gun_model.sv
// line timebase and gun cylinder model facing the sequencer valves
`timescale 1ns/1ps
module aos_gun_model #(
    parameter int HALF_CLKS = 4
) (
    input  wire logic       sys_clk,
    input  wire logic       reset_n,
    input  wire logic       extend_valve,
    input  wire logic       third_valve_terminal,
    output logic            line_half_tick,
    output logic      [7:0] gun_pos
);
    int tick_cnt = 0;
    // the line keeps running through reset, so the tick never stops
    always_ff @(posedge sys_clk)
    begin
        tick_cnt       <= (tick_cnt >= HALF_CLKS - 1) ? 0 : tick_cnt + 1;
        line_half_tick <= (tick_cnt == HALF_CLKS - 1);
    end
    // blocking valve holds the stroke; with no valve the gun falls open
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
            gun_pos <= 8'h00;
        else if (extend_valve && gun_pos != 8'hff)
            gun_pos <= gun_pos + 8'h01;
        else if (!third_valve_terminal && gun_pos != 8'h00)
            gun_pos <= gun_pos - 8'h01;
    end
endmodule : aos_gun_model

// ===== tb/air_oil_retraction_sequencer_test.sv
// self-checking bench for the air-over-oil sequencer
`timescale 1ns/1ps
module air_oil_retraction_sequencer_test;
    typedef struct {
        logic [11:0] a;
        logic        w;
        logic [31:0] d;
        logic [31:0] e;
        logic        err;
    } aos_row_t;
    logic sys_clk, reset_n, psel, penable, pwrite, pready, pslverr, tick;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic tgl, ini, stp, rsw, ext, ints, thr, weld, sq_led, off_led, v3_led;
    logic [7:0] gun_pos;
    logic sq_prev, off_prev, er;
    int fail_count, comparisons, sq_dim, off_dim, i, k;
    aos_row_t rows [11] = '{
        '{12'h000, 1'b0, 32'h0, 32'h0, 1'b0},
        '{12'h004, 1'b0, 32'h0, 32'h0, 1'b0},
        '{12'h008, 1'b0, 32'h0, 32'h0, 1'b1},
        '{12'h000, 1'b1, 32'h7, 32'h0, 1'b0},
        '{12'h004, 1'b1, 32'h8, 32'h0, 1'b0},
        '{12'h008, 1'b1, 32'h1, 32'h0, 1'b0},
        '{12'h008, 1'b0, 32'h0, 32'h1, 1'b0},
        '{12'h00c, 1'b1, 32'h301, 32'h0, 1'b0},
        '{12'h010, 1'b1, 32'h10101, 32'h0, 1'b0},
        '{12'h018, 1'b0, 32'h0, 32'h0, 1'b1},
        '{12'h014, 1'b1, 32'h1, 32'h0, 1'b1}};
    aos_sequencer #(.DEB_CYCLES(4)) dut_u (.sys_clk(sys_clk),
        .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .line_half_tick(tick), .toggle_input(tgl),
        .initiation_input(ini), .estop_input(stp),
        .retraction_switch_input(rsw), .extend_valve(ext),
        .intensify_valve(ints), .third_valve_terminal(thr),
        .weld_enable(weld), .squeeze_led(sq_led), .off_led(off_led),
        .valve3_led(v3_led));
    aos_gun_model gun_u (.sys_clk(sys_clk), .reset_n(reset_n),
        .extend_valve(ext), .third_valve_terminal(thr),
        .line_half_tick(tick), .gun_pos(gun_pos));
    initial
    begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // counts cycles in which a lamp changes, whether dimmed or simply switched on or off
    always @(posedge sys_clk)
    begin
        sq_prev <= sq_led;
        off_prev <= off_led;
        if (reset_n && sq_led !== sq_prev) sq_dim++;
        if (reset_n && off_led !== off_prev) off_dim++;
    end
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e)
        begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic apb(input logic [11:0] a, input logic w,
                       input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge sys_clk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        if (n == 50) begin chk(32'h0, 32'h1); wrap_up(); end
    endtask : apb
    function automatic logic outv(input int s);
        case (s)
            0: return ext;
            1: return ints;
            2: return thr;
            3: return weld;
            default: return v3_led;
        endcase
    endfunction : outv
    task automatic wait_out(input int s, input logic v);
        int n;
        for (n = 0; n < 400 && outv(s) !== v; n++) @(negedge sys_clk);
        if (n == 400) begin chk({31'h0, outv(s)}, {31'h0, v}); wrap_up(); end
    endtask : wait_out
    task automatic press(input int s);
        @(posedge sys_clk);
        if (s == 0) tgl <= 1'b1; else if (s == 1) ini <= 1'b1;
        else stp <= 1'b1;
        repeat (12) @(posedge sys_clk);
        tgl <= 1'b0; ini <= 1'b0; stp <= 1'b0;
        repeat (12) @(posedge sys_clk);
    endtask : press
    initial
    begin
        {reset_n, psel, penable, pwrite, tgl, ini, stp, rsw} = 8'h00;
        paddr = 12'h000; pwdata = 32'h0;
        repeat (20) @(posedge sys_clk);
        reset_n <= 1'b1;
        foreach (rows[i])
        begin
            apb(rows[i].a, rows[i].w, rows[i].d);
            chk({rd[30:0], er}, {rows[i].e[30:0], rows[i].err});
        end
        $display("test registers done");
        ini <= 1'b1;
        wait_out(0, 1'b1);
        chk({30'h0, ints, thr}, 32'h0);
        wait_out(1, 1'b1);
        chk({31'h0, ext}, 32'h1);
        wait_out(3, 1'b1);
        @(posedge sys_clk);
        ini <= 1'b0;
        wait_out(2, 1'b1);
        chk({30'h0, ext, ints}, 32'h0);
        chk({31'h0, sq_dim > 0 && off_dim > 0}, 32'h1);
        repeat (40) @(posedge sys_clk);
        chk({31'h0, thr}, 32'h1);
        wait_out(4, 1'b1);
        apb(12'h000, 1'b1, 32'h0);
        chk({31'h0, er}, 32'h1);
        $display("test full sequence done");
        k = sq_dim;
        press(1);
        wait_out(0, 1'b1);
        chk({31'h0, thr}, 32'h0);
        wait_out(2, 1'b1);
        // full-bright squeeze lamp: one rise and one fall only
        chk(sq_dim, k + 2);
        $display("test blocked start done");
        press(0);
        wait_out(2, 1'b0);
        press(0);
        wait_out(0, 1'b1);
        wait_out(0, 1'b0);
        chk({31'h0, thr}, 32'h0);
        wait_out(2, 1'b1);
        chk({31'h0, gun_pos != 8'h00}, 32'h1);
        $display("test toggle done");
        @(posedge sys_clk);
        ini <= 1'b1;
        wait_out(0, 1'b1);
        press(2);
        ini <= 1'b0;
        chk({27'h0, v3_led, ext, ints, thr, weld}, 32'h0);
        repeat (40) @(posedge sys_clk);
        chk({31'h0, thr}, 32'h0);
        $display("test stop done");
        apb(12'h000, 1'b1, 32'h0);
        apb(12'h008, 1'b0, 32'h0);
        chk({31'h0, er}, 32'h1);
        press(1);
        repeat (40) @(posedge sys_clk);
        chk({31'h0, ext}, 32'h0);
        $display("test selector off done");
        apb(12'h000, 1'b1, 32'h10007);
        ini <= 1'b1;
        wait_out(3, 1'b1);
        wait_out(3, 1'b0);
        wait_out(3, 1'b1);
        chk({31'h0, thr}, 32'h0);
        @(posedge sys_clk);
        ini <= 1'b0;
        wait_out(2, 1'b1);
        press(2);
        $display("test repeat done");
        rsw <= 1'b1;
        repeat (20) @(posedge sys_clk);
        apb(12'h000, 1'b1, 32'h900);
        repeat (20) @(posedge sys_clk);
        chk({31'h0, thr}, 32'h0);
        rsw <= 1'b0;
        repeat (20) @(posedge sys_clk);
        rsw <= 1'b1;
        wait_out(2, 1'b1);
        $display("test maintained done");
        wrap_up();
    end
endmodule : air_oil_retraction_sequencer_test
